// ===== shared/tsreg_pkg.sv
// Package for the timestamp value, tick rate and identification register bank.
// Assumes both programming ports use 12-bit byte addresses within one 4KB region.
package tsreg_pkg;

  // Bus and counter widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 64;

  // Control programming port offsets
  localparam logic [11:0] OFF_CTL_LOWER = 12'h008;
  localparam logic [11:0] OFF_CTL_UPPER = 12'h00C;
  localparam logic [11:0] OFF_CTL_RATE  = 12'h020;

  // Read-only programming port offsets
  localparam logic [11:0] OFF_RO_LOWER  = 12'h000;
  localparam logic [11:0] OFF_RO_UPPER  = 12'h004;

  // Identification offsets, shared by both ports
  localparam logic [11:0] OFF_ID4       = 12'hFD0;
  localparam logic [11:0] OFF_ID0       = 12'hFE0;
  localparam logic [11:0] OFF_ID1       = 12'hFE4;

  // Reset values
  localparam logic [31:0] RST_RATE      = 32'h0000_0000;
  localparam logic [31:0] RST_LOWER     = 32'h0000_0000;
  localparam logic [63:0] RST_COUNT     = 64'h0000_0000_0000_0000;

  // Identification field positions and fixed size code
  localparam int          ID_FIELD_LSB  = 0;
  localparam int          ID_HIGH_LSB   = 4;
  localparam int          ID_PART_SPLIT = 8;
  localparam logic [3:0]  ID_SIZE_4KB   = 4'h0;

endpackage

// ===== core/tsreg_apb_slave.sv
// Slave end of one programming port with APB-style setup and access phases.
// Assumes the caller decodes the address and presents read data in the setup phase.
`timescale 1ns/1ns
module tsreg_apb_slave (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_b,
  // Port pins
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  // Read word chosen from the address in the setup phase
  input  wire logic [31:0] i_rd_word,
  // Port answers
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Decoded strobes
  output logic             o_setup_rd,
  output logic             o_wr_stb
);

  ////////////////////////////////////////////////////////////////////////////////
  // Phase decode: reads sample in setup, writes commit in access
  assign o_setup_rd = i_psel & ~i_penable & ~i_pwrite;
  assign o_wr_stb   = i_psel & i_penable & i_pwrite;
  assign o_pready   = 1'b1;   // No wait states
  assign o_pslverr  = 1'b0;   // Unmapped reads return zero

  ////////////////////////////////////////////////////////////////////////////////
  // Read data flop, stable through the access phase
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_prdata <= 32'h0000_0000;
    end else if (o_setup_rd) begin
      o_prdata <= i_rd_word;
    end
  end

endmodule

// ===== core/tsreg_counter.sv
// Local 64-bit timestamp count with whole-word load.
// Assumes enable and halt come from control logic on the same clock.
`timescale 1ns/1ns
module tsreg_counter #(
  parameter int CNT_W = 64
) (
  // Clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst_b,
  // Controls
  input  wire logic             i_enable,
  input  wire logic             i_halt,
  input  wire logic             i_load,
  input  wire logic [CNT_W-1:0] i_load_value,
  // Count
  output logic      [CNT_W-1:0] o_count
);

  logic [CNT_W-1:0] next_count;

  ////////////////////////////////////////////////////////////////////////////////
  // Load wins; otherwise step only while enabled and not halted
  assign next_count = i_load ? i_load_value :
                      (i_enable & ~i_halt) ? o_count + CNT_W'(1) : o_count;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_count <= CNT_W'(0);
    end else begin
      o_count <= next_count;
    end
  end

endmodule

// ===== core/tsreg_top.sv
// Timestamp value, tick rate and identification register bank with its counter.
// Assumes a control port and a read-only port, both on i_ref_clk, APB-style.
//
// Contract
// - Writing the upper value register loads all 64 bits at once from held lower and new upper.
// - Reading the upper value register returns count bits 63 to 32.
// - The tick rate register is reachable only from the control port.
// - The tick rate is one 32-bit read-write field filling the register.
// - Bits 7 to 4 of the size and continuation identification register read zero.
// - Bits 3 to 0 of that register return the fixed designer continuation code.
// - Bits 7 to 0 of the part-low identification register return part number bits 7 to 0.
// - Bits 3 to 0 of the next identification register return part number bits 11 to 8.
// - Bits 7 to 4 of that register return the low designer identity nibble.
// - The read-only port reads the value words and its writes never change the count.
// - The count steps only while the counter enable bit is one and the halt input is zero, and otherwise holds unless an upper value write loads it.
`timescale 1ns/1ns
module tsreg_top #(
  parameter logic [11:0] PART_NUMBER  = 12'h2C5,  // Arbitrary value
  parameter logic [3:0]  DESIGNER_LOW = 4'hA,     // Arbitrary value
  parameter logic [3:0]  DESIGNER_CONT = 4'h5     // Arbitrary value
) (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_b,
  // Control programming port
  input  wire logic        i_ctl_psel,
  input  wire logic        i_ctl_penable,
  input  wire logic        i_ctl_pwrite,
  input  wire logic [11:0] i_ctl_paddr,
  input  wire logic [31:0] i_ctl_pwdata,
  output logic      [31:0] o_ctl_prdata,
  output logic             o_ctl_pready,
  output logic             o_ctl_pslverr,
  // Read-only programming port
  input  wire logic        i_ro_psel,
  input  wire logic        i_ro_penable,
  input  wire logic        i_ro_pwrite,
  input  wire logic [11:0] i_ro_paddr,
  input  wire logic [31:0] i_ro_pwdata,
  output logic      [31:0] o_ro_prdata,
  output logic             o_ro_pready,
  output logic             o_ro_pslverr,
  // Counter controls from the control register
  input  wire logic        i_counter_enable_bit,
  input  wire logic        i_halt_on_debug,
  // Counter view
  output logic      [63:0] o_count,
  output logic             o_count_loaded,
  output logic      [31:0] o_ticks_per_second
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [31:0] count_value_lower;   // Held lower word awaiting upper write
  logic [31:0] base_tick_rate;
  logic [31:0] ident_size_designer_cont;
  logic [31:0] ident_part_low;
  logic [31:0] ident_part_high_designer_low;
  logic [31:0] ctl_rd_word;
  logic [31:0] ro_rd_word;
  logic [63:0] load_value;
  logic        ctl_setup_rd;
  logic        ctl_wr_stb;
  logic        ro_setup_rd;
  logic        ro_wr_stb;
  logic        wr_lower;
  logic        wr_upper;
  logic        wr_rate;
  logic        ctl_hit_id4;
  logic        ctl_hit_id0;
  logic        ctl_hit_id1;
  logic        ro_hit_id4;
  logic        ro_hit_id0;
  logic        ro_hit_id1;

  ////////////////////////////////////////////////////////////////////////////////
  // Identification constants, reserved bits zero
  assign ident_size_designer_cont     = {24'h00_0000, tsreg_pkg::ID_SIZE_4KB,
                                         DESIGNER_CONT};
  assign ident_part_low               = {24'h00_0000,
                                         PART_NUMBER[tsreg_pkg::ID_PART_SPLIT-1:0]};
  assign ident_part_high_designer_low = {24'h00_0000, DESIGNER_LOW,
                                         PART_NUMBER[11:tsreg_pkg::ID_PART_SPLIT]};

  ////////////////////////////////////////////////////////////////////////////////
  // Control port address decode
  assign ctl_hit_id4 = (i_ctl_paddr == tsreg_pkg::OFF_ID4);
  assign ctl_hit_id0 = (i_ctl_paddr == tsreg_pkg::OFF_ID0);
  assign ctl_hit_id1 = (i_ctl_paddr == tsreg_pkg::OFF_ID1);
  assign wr_lower    = ctl_wr_stb & (i_ctl_paddr == tsreg_pkg::OFF_CTL_LOWER);
  assign wr_upper    = ctl_wr_stb & (i_ctl_paddr == tsreg_pkg::OFF_CTL_UPPER);
  assign wr_rate     = ctl_wr_stb & (i_ctl_paddr == tsreg_pkg::OFF_CTL_RATE);

  // Control port read mux; identification writes fall through to nothing
  assign ctl_rd_word =
    (i_ctl_paddr == tsreg_pkg::OFF_CTL_LOWER) ? o_count[31:0]  :
    (i_ctl_paddr == tsreg_pkg::OFF_CTL_UPPER) ? o_count[63:32] :
    (i_ctl_paddr == tsreg_pkg::OFF_CTL_RATE)  ? base_tick_rate :
    ctl_hit_id4 ? ident_size_designer_cont :
    ctl_hit_id0 ? ident_part_low :
    ctl_hit_id1 ? ident_part_high_designer_low : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////////
  // Read-only port decode; tick rate is not mapped here
  assign ro_hit_id4 = (i_ro_paddr == tsreg_pkg::OFF_ID4);
  assign ro_hit_id0 = (i_ro_paddr == tsreg_pkg::OFF_ID0);
  assign ro_hit_id1 = (i_ro_paddr == tsreg_pkg::OFF_ID1);
  assign ro_rd_word =
    (i_ro_paddr == tsreg_pkg::OFF_RO_LOWER) ? o_count[31:0]  :
    (i_ro_paddr == tsreg_pkg::OFF_RO_UPPER) ? o_count[63:32] :
    ro_hit_id4 ? ident_size_designer_cont :
    ro_hit_id0 ? ident_part_low :
    ro_hit_id1 ? ident_part_high_designer_low : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////////
  // Port slaves
  tsreg_apb_slave u_ctl_port (
    .i_ref_clk  (i_ref_clk),
    .i_rst_b    (i_rst_b),
    .i_psel     (i_ctl_psel),
    .i_penable  (i_ctl_penable),
    .i_pwrite   (i_ctl_pwrite),
    .i_rd_word  (ctl_rd_word),
    .o_prdata   (o_ctl_prdata),
    .o_pready   (o_ctl_pready),
    .o_pslverr  (o_ctl_pslverr),
    .o_setup_rd (ctl_setup_rd),
    .o_wr_stb   (ctl_wr_stb)
  );

  // Writes decoded here are dropped on purpose
  tsreg_apb_slave u_ro_port (
    .i_ref_clk  (i_ref_clk),
    .i_rst_b    (i_rst_b),
    .i_psel     (i_ro_psel),
    .i_penable  (i_ro_penable),
    .i_pwrite   (i_ro_pwrite),
    .i_rd_word  (ro_rd_word),
    .o_prdata   (o_ro_prdata),
    .o_pready   (o_ro_pready),
    .o_pslverr  (o_ro_pslverr),
    .o_setup_rd (ro_setup_rd),
    .o_wr_stb   (ro_wr_stb)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Held lower word and tick rate registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      count_value_lower <= tsreg_pkg::RST_LOWER;
      base_tick_rate    <= tsreg_pkg::RST_RATE;
    end else begin
      if (wr_lower) begin
        count_value_lower <= i_ctl_pwdata;
      end
      if (wr_rate) begin
        base_tick_rate <= i_ctl_pwdata;
      end
    end
  end

  assign o_ticks_per_second = base_tick_rate;

  ////////////////////////////////////////////////////////////////////////////////
  // Whole 64-bit load on the upper word write
  assign load_value = {i_ctl_pwdata, count_value_lower};

  tsreg_counter #(
    .CNT_W (tsreg_pkg::CNT_W)
  ) u_counter (
    .i_ref_clk    (i_ref_clk),
    .i_rst_b      (i_rst_b),
    .i_enable     (i_counter_enable_bit),
    .i_halt       (i_halt_on_debug),
    .i_load       (wr_upper),
    .i_load_value (load_value),
    .o_count      (o_count)
  );

  // Pulse marks the cycle the loaded count appears
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_count_loaded <= 1'b0;
    end else begin
      o_count_loaded <= wr_upper;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_lower_write;
    wr_lower;
  endsequence

  sequence s_upper_write;
    wr_upper;
  endsequence

  sequence s_ctl_read(logic [11:0] off);
    ctl_setup_rd && i_ctl_paddr == off;
  endsequence

  sequence s_ro_read(logic [11:0] off);
    ro_setup_rd && i_ro_paddr == off;
  endsequence

  a_upper_whole_load: assert property (
    s_upper_write |=> o_count == {$past(i_ctl_pwdata), $past(count_value_lower)} && o_count_loaded)
    else $error("count not loaded from both words");

  // Lower write, two quiet cycles, then the upper write: the written lower word must land
  a_lower_held_load: assert property (
    s_lower_write ##1 (!wr_lower [*2]) ##1 s_upper_write
      |=> o_count[31:0] == $past(i_ctl_pwdata, 4))
    else $error("held lower word lost before upper write");

  a_upper_read_value: assert property (
    s_ctl_read(tsreg_pkg::OFF_CTL_UPPER) |=> o_ctl_prdata == $past(o_count[63:32]))
    else $error("upper read mismatch");

  a_rate_hidden_ro: assert property (
    s_ro_read(tsreg_pkg::OFF_CTL_RATE) |=> o_ro_prdata == 32'h0000_0000)
    else $error("tick rate visible on read-only port");

  // Rate write, one idle cycle, then a read setup of the rate
  a_rate_write_read: assert property (
    wr_rate ##2 s_ctl_read(tsreg_pkg::OFF_CTL_RATE) |=> o_ctl_prdata == $past(i_ctl_pwdata, 3))
    else $error("tick rate not kept");

  a_size_field_zero: assert property (
    s_ctl_read(tsreg_pkg::OFF_ID4) |=> o_ctl_prdata[7:4] == 4'h0)
    else $error("size field not zero");

  a_size_zero_ro: assert property (
    s_ro_read(tsreg_pkg::OFF_ID4) |=> o_ro_prdata[7:4] == 4'h0)
    else $error("size field not zero on read-only port");

  a_designer_cont: assert property (
    s_ctl_read(tsreg_pkg::OFF_ID4) |=> o_ctl_prdata == {28'h000_0000, DESIGNER_CONT})
    else $error("continuation code wrong");

  a_part_low_read: assert property (
    s_ro_read(tsreg_pkg::OFF_ID0) |=> o_ro_prdata == {24'h00_0000, PART_NUMBER[7:0]})
    else $error("part low wrong");

  a_part_high_des: assert property (
    s_ctl_read(tsreg_pkg::OFF_ID1)
      |=> o_ctl_prdata == {24'h00_0000, DESIGNER_LOW, PART_NUMBER[11:8]})
    else $error("part high or designer low wrong");

  a_ident_reserved: assert property (
    s_ctl_read(tsreg_pkg::OFF_ID0) |=> o_ctl_prdata[31:8] == 24'h00_0000)
    else $error("identification reserved bits set");

  a_ro_write_inert: assert property (
    ro_wr_stb && !wr_upper && !i_counter_enable_bit |=> o_count == $past(o_count))
    else $error("read-only write changed count");

  a_count_holds: assert property (
    !i_counter_enable_bit && !wr_upper |=> $stable(o_count))
    else $error("count moved while disabled");

  a_count_steps: assert property (
    i_counter_enable_bit && !i_halt_on_debug && !wr_upper
      |=> o_count == $past(o_count) + 64'h0000_0000_0000_0001)
    else $error("count did not step");

endmodule

// ===== verification/tsreg_tb.sv
// Self-checking bench for the timestamp value, tick rate and identification bank.
// Assumes the design modules and shared/tsreg_pkg.sv are compiled beforehand.
`timescale 1ns/1ns
module testbench;
  localparam logic [11:0] PART  = 12'h2C5;  // Arbitrary value
  localparam logic [3:0]  DLOW  = 4'hA;     // Arbitrary value
  localparam logic [3:0]  DCONT = 4'h5;     // Arbitrary value

  logic        clk;
  logic        rst_b;
  logic        sel [2];
  logic        en  [2];
  logic        wrt [2];
  logic [11:0] adr [2];
  logic [31:0] wd  [2];
  logic [31:0] rd  [2];
  logic        rdy [2];
  logic        err [2];
  logic        en_bit;
  logic        halt;
  logic [63:0] count;
  logic        loaded;
  logic [31:0] rate;
  int          fails;
  int          compares;
  int          cycles;

  ////////////////////////////////////////////////////////////////////////////
  // Device under test, port 0 is control and port 1 is read-only
  tsreg_top #(.PART_NUMBER(PART), .DESIGNER_LOW(DLOW), .DESIGNER_CONT(DCONT)) dut (
    .i_ref_clk(clk), .i_rst_b(rst_b),
    .i_ctl_psel(sel[0]), .i_ctl_penable(en[0]), .i_ctl_pwrite(wrt[0]),
    .i_ctl_paddr(adr[0]), .i_ctl_pwdata(wd[0]), .o_ctl_prdata(rd[0]),
    .o_ctl_pready(rdy[0]), .o_ctl_pslverr(err[0]),
    .i_ro_psel(sel[1]), .i_ro_penable(en[1]), .i_ro_pwrite(wrt[1]),
    .i_ro_paddr(adr[1]), .i_ro_pwdata(wd[1]), .o_ro_prdata(rd[1]),
    .o_ro_pready(rdy[1]), .o_ro_pslverr(err[1]),
    .i_counter_enable_bit(en_bit), .i_halt_on_debug(halt),
    .o_count(count), .o_count_loaded(loaded), .o_ticks_per_second(rate));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      $display("wrong value at %0t: run did not finish", $time);
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare and report one value
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // One transfer with an idle cycle in front, setup then access phase
  task automatic xfer(input int p, input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    #1 sel[p] = 1'b1;
    wrt[p] = w;
    adr[p] = a;
    wd[p]  = d;
    @(posedge clk);
    #1 en[p] = 1'b1;
    @(posedge clk);
    q = rd[p];
    chk({63'h0, rdy[p]}, 64'h1, "ready");
    chk({63'h0, err[p]}, 64'h0, "error flag");
    #1 sel[p] = 1'b0;
    en[p] = 1'b0;
  endtask

  task automatic wr32(input int p, input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(p, 1'b1, a, d, q);
  endtask

  task automatic rd32(input int p, input logic [11:0] a, input logic [31:0] exp,
                      input string msg);
    logic [31:0] q;
    xfer(p, 1'b0, a, 32'h0000_0000, q);
    chk({32'h0, q}, {32'h0, exp}, msg);
  endtask

  // Verdict and end of run
  task automatic results();
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    logic [11:0] id_adr [3];
    logic [31:0] id_exp [3];
    id_adr = '{tsreg_pkg::OFF_ID4, tsreg_pkg::OFF_ID0, tsreg_pkg::OFF_ID1};
    id_exp = '{{24'h0, 4'h0, DCONT}, {24'h0, PART[7:0]}, {24'h0, DLOW, PART[11:8]}};
    fails = 0;
    compares = 0;
    cycles = 0;
    rst_b = 1'b0;
    en_bit = 1'b0;
    halt = 1'b0;
    for (int p = 0; p < 2; p++) begin
      sel[p] = 1'b0;
      en[p] = 1'b0;
      wrt[p] = 1'b0;
      adr[p] = 12'h000;
      wd[p] = 32'h0000_0000;
    end
    repeat (10) @(posedge clk);
    #1 rst_b = 1'b1;
    chk(count, 64'h0, "count after reset");
    chk({32'h0, rate}, 64'h0, "rate after reset");
    $display("test reset done");

    // Identification words on both ports, read after write attempts from the control port
    for (int i = 0; i < 3; i++) wr32(0, id_adr[i], 32'hFFFF_FFFF);
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 3; i++) rd32(p, id_adr[i], id_exp[i], "ident");
    $display("test ident done");

    // Tick rate, full width, hidden from the read-only port
    wr32(0, tsreg_pkg::OFF_CTL_RATE, 32'h02FA_F080);
    rd32(0, tsreg_pkg::OFF_CTL_RATE, 32'h02FA_F080, "rate");
    wr32(0, tsreg_pkg::OFF_CTL_RATE, 32'hFFFF_FFFF);
    rd32(0, tsreg_pkg::OFF_CTL_RATE, 32'hFFFF_FFFF, "rate max");
    wr32(1, tsreg_pkg::OFF_CTL_RATE, 32'h0000_1234);
    rd32(1, tsreg_pkg::OFF_CTL_RATE, 32'h0000_0000, "rate from ro");
    chk({32'h0, rate}, 64'h0000_0000_FFFF_FFFF, "rate output");
    rd32(0, 12'h100, 32'h0000_0000, "unmapped");
    $display("test rate done");

    // Two-step load with the counter stopped
    wr32(0, tsreg_pkg::OFF_CTL_LOWER, 32'hFFFF_FFFE);
    chk(count, 64'h0, "lower alone");
    wr32(0, tsreg_pkg::OFF_CTL_UPPER, 32'h1234_5678);
    chk(count, 64'h1234_5678_FFFF_FFFE, "loaded count");
    chk({63'h0, loaded}, 64'h1, "load pulse");
    repeat (4) @(posedge clk);
    #1 chk({63'h0, loaded}, 64'h0, "load pulse end");
    chk(count, 64'h1234_5678_FFFF_FFFE, "held while disabled");
    rd32(0, tsreg_pkg::OFF_CTL_LOWER, 32'hFFFF_FFFE, "lower ctl");
    rd32(0, tsreg_pkg::OFF_CTL_UPPER, 32'h1234_5678, "upper ctl");
    rd32(1, tsreg_pkg::OFF_RO_UPPER, 32'h1234_5678, "upper ro");
    rd32(1, tsreg_pkg::OFF_RO_LOWER, 32'hFFFF_FFFE, "lower ro");
    wr32(1, tsreg_pkg::OFF_RO_UPPER, 32'h0000_0000);
    wr32(1, tsreg_pkg::OFF_RO_LOWER, 32'h0000_0000);
    chk(count, 64'h1234_5678_FFFF_FFFE, "ro writes");
    $display("test load done");

    // Counting, halt, and carry into the upper word
    en_bit = 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(count, 64'h1234_5679_0000_0001, "three steps");
    halt = 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(count, 64'h1234_5679_0000_0001, "halted");
    en_bit = 1'b0;
    halt = 1'b0;
    repeat (3) @(posedge clk);
    #1 chk(count, 64'h1234_5679_0000_0001, "disabled");
    rd32(0, tsreg_pkg::OFF_CTL_UPPER, 32'h1234_5679, "upper after carry");
    $display("test count done");
    results();
  end
endmodule
